/* design/mdu_pkg.sv */
// Package of constants and types for the multiply/divide coprocessor
package mdu_pkg;

  localparam int MDU_DATA_W   = 16;
  localparam int MDU_RES_W    = 32;
  localparam int MDU_MODE_W   = 7;

  // Mode register field layout
  localparam int MDU_OP_LSB   = 0;
  localparam int MDU_OP_MSB   = 3;
  localparam int MDU_OUT_LSB  = 4;
  localparam int MDU_OUT_MSB  = 6;

  localparam logic [6:0]  MDU_MODE_RESET = 7'h03;
  localparam logic [31:0] MDU_RES_RESET  = 32'h0000_0000;

  // Output mode codes
  localparam logic [2:0] MDU_OUT_LOW  = 3'h0;
  localparam logic [2:0] MDU_OUT_HIGH = 3'h1;

  // Operation mode codes
  localparam logic [3:0] MDU_OP_CLEAR   = 4'h0;
  localparam logic [3:0] MDU_OP_LOAD16  = 4'h1;
  localparam logic [3:0] MDU_OP_LOAD32  = 4'h2;
  localparam logic [3:0] MDU_OP_READ    = 4'h3;
  localparam logic [3:0] MDU_OP_UMUL    = 4'h4;
  localparam logic [3:0] MDU_OP_SMUL    = 4'h5;
  localparam logic [3:0] MDU_OP_SMAC    = 4'h7;
  localparam logic [3:0] MDU_OP_UDIV    = 4'h8;
  localparam logic [3:0] MDU_OP_SDIV    = 4'h9;

  // Divider timing: one setup, sixteen steps, one fixup cycle
  localparam int MDU_DIV_STEPS = 16;

  // Flag positions within the flags field of mdu_answer_t
  localparam int MDU_FLAG_C = 3;
  localparam int MDU_FLAG_V = 2;
  localparam int MDU_FLAG_Z = 1;
  localparam int MDU_FLAG_N = 0;
  localparam logic [3:0] MDU_FLAGS_NONE = 4'h0;

  // Operand transfer from the CPU
  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } mdu_operands_t;

  // Answer to the CPU
  typedef struct packed {
    logic [15:0] data;
    logic [3:0]  flags;
  } mdu_answer_t;

endpackage : mdu_pkg

/* design/mdu_divider.sv */
// Sequential restoring divider, signed or unsigned, 16 by 16 bits
`timescale 1ns/1ps
module mdu_divider
  import mdu_pkg::*;
#(
  parameter int W = MDU_DATA_W
)(
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         start_i,
  input  wire logic         signed_i,
  input  wire logic [W-1:0] dividend_i,
  input  wire logic [W-1:0] divisor_i,
  output logic              done_o,
  output logic [W-1:0]      quotient_o,
  output logic [W-1:0]      remainder_o
);

  typedef enum logic [1:0] {MDU_DV_IDLE, MDU_DV_STEP, MDU_DV_FIX} mdu_dv_state_t;

  mdu_dv_state_t state;
  mdu_dv_state_t next_state;
  logic [W-1:0]  quo;
  logic [W-1:0]  next_quo;
  logic [W:0]    rem;
  logic [W:0]    next_rem;
  logic [W-1:0]  dsr;
  logic [W-1:0]  next_dsr;
  logic [4:0]    cnt;
  logic [4:0]    next_cnt;
  logic          neg_q;
  logic          next_neg_q;
  logic          neg_r;
  logic          next_neg_r;
  logic [W-1:0]  q_out;
  logic [W-1:0]  next_q_out;
  logic [W-1:0]  r_out;
  logic [W-1:0]  next_r_out;
  logic          done;
  logic          next_done;

  function automatic logic [W-1:0] mdu_abs(input logic [W-1:0] v, input logic s);
    mdu_abs = (s && v[W-1]) ? W'(-v) : v;
  endfunction : mdu_abs

  always_comb
  begin
    logic [W:0] trial;
    trial      = '0;
    next_state = state;
    next_quo   = quo;
    next_rem   = rem;
    next_dsr   = dsr;
    next_cnt   = cnt;
    next_neg_q = neg_q;
    next_neg_r = neg_r;
    next_q_out = q_out;
    next_r_out = r_out;
    next_done  = 1'b0;
    case (state)
      MDU_DV_IDLE:
      begin
        if (start_i)
        begin
          next_quo   = mdu_abs(dividend_i, signed_i);
          next_dsr   = mdu_abs(divisor_i, signed_i);
          next_rem   = '0;
          next_cnt   = '0;
          next_neg_q = signed_i && (dividend_i[W-1] ^ divisor_i[W-1]);
          next_neg_r = signed_i && dividend_i[W-1];
          next_state = MDU_DV_STEP;
        end
      end
      MDU_DV_STEP:
      begin
        trial = {rem[W-1:0], quo[W-1]} - {1'b0, dsr};
        if (!trial[W])
        begin
          next_rem = trial;
          next_quo = {quo[W-2:0], 1'b1};
        end
        else
        begin
          next_rem = {rem[W-1:0], quo[W-1]};
          next_quo = {quo[W-2:0], 1'b0};
        end
        next_cnt = cnt + 5'h01;
        if (cnt == 5'(MDU_DIV_STEPS - 1))
        begin
          next_state = MDU_DV_FIX;
        end
      end
      MDU_DV_FIX:
      begin
        next_q_out = neg_q ? W'(-quo) : quo;
        next_r_out = neg_r ? W'(-rem[W-1:0]) : rem[W-1:0];
        next_done  = 1'b1;
        next_state = MDU_DV_IDLE;
      end
      default:
      begin
        next_state = MDU_DV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state <= MDU_DV_IDLE;
      quo   <= '0;
      rem   <= '0;
      dsr   <= '0;
      cnt   <= '0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      q_out <= '0;
      r_out <= '0;
      done  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      quo   <= next_quo;
      rem   <= next_rem;
      dsr   <= next_dsr;
      cnt   <= next_cnt;
      neg_q <= next_neg_q;
      neg_r <= next_neg_r;
      q_out <= next_q_out;
      r_out <= next_r_out;
      done  <= next_done;
    end
  end

  assign done_o      = done;
  assign quotient_o  = q_out;
  assign remainder_o = r_out;

endmodule : mdu_divider

/* design/mdu_core.sv */
// Multiply, multiply-accumulate and divide coprocessor facing the CPU core
`timescale 1ns/1ps
module mdu_core
  import mdu_pkg::*;
#(
  parameter int W = MDU_DATA_W
)(
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          mode_wr_i,
  input  wire logic [15:0]   mode_data_i,
  input  wire logic          op_send_i,
  input  wire logic          init_send_i,
  input  wire mdu_operands_t operands_i,
  output logic               busy_o,
  output logic               ans_valid_o,
  output mdu_answer_t        answer_o,
  output logic [6:0]         mode_o
);

  typedef enum logic [1:0] {MDU_IDLE, MDU_DIV_WAIT} mdu_state_t;

  logic [MDU_MODE_W-1:0] mode_reg;
  logic [MDU_MODE_W-1:0] next_mode_reg;
  logic [MDU_RES_W-1:0]  res;
  logic [MDU_RES_W-1:0]  next_res;
  mdu_state_t            state;
  mdu_state_t            next_state;
  logic                  ans_valid;
  logic                  next_ans_valid;
  mdu_answer_t           answer;
  mdu_answer_t           next_answer;
  logic                  div_start;
  logic                  div_done;
  logic [W-1:0]          div_q;
  logic [W-1:0]          div_r;
  logic [3:0]            op_mode;
  logic [2:0]            out_mode;
  logic [31:0]           prod_u;
  logic [31:0]           prod_s;
  logic [31:0]           mac_sum;
  logic                  mac_ovf;

  // Selects the half of a result word named by the output mode
  function automatic logic [15:0] mdu_half(input logic [31:0] v, input logic [2:0] om);
    if (om == MDU_OUT_HIGH)
      mdu_half = v[31:16];
    else if (om == MDU_OUT_LOW)
      mdu_half = v[15:0];
    else
      mdu_half = 16'h0000;
  endfunction : mdu_half

  assign op_mode  = mode_reg[MDU_OP_MSB:MDU_OP_LSB];
  assign out_mode = mode_reg[MDU_OUT_MSB:MDU_OUT_LSB];

  // Products and accumulate sum
  assign prod_u  = {16'h0000, operands_i.first} * {16'h0000, operands_i.second};
  assign prod_s  = 32'($signed(operands_i.first) * $signed(operands_i.second));
  assign mac_sum = prod_s + res;
  assign mac_ovf = (prod_s[31] == res[31]) && (mac_sum[31] != res[31]);

  assign div_start = (state == MDU_IDLE) && (op_send_i || init_send_i) && !mode_wr_i
                     && ((op_mode == MDU_OP_UDIV) || (op_mode == MDU_OP_SDIV));

  mdu_divider #(
    .W (W)
  ) u_div (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (div_start),
    .signed_i    (op_mode == MDU_OP_SDIV),
    .dividend_i  (operands_i.first),
    .divisor_i   (operands_i.second),
    .done_o      (div_done),
    .quotient_o  (div_q),
    .remainder_o (div_r)
  );

  always_comb
  begin
    logic send;
    send           = (op_send_i || init_send_i) && !mode_wr_i && (state == MDU_IDLE);
    next_mode_reg  = mode_reg;
    next_res       = res;
    next_state     = state;
    next_ans_valid = 1'b0;
    next_answer    = answer;
    if (mode_wr_i && (state == MDU_IDLE))
    begin
      next_mode_reg = mode_data_i[6:0];
      if (mode_data_i[MDU_OP_MSB:MDU_OP_LSB] == MDU_OP_CLEAR)
        next_res = MDU_RES_RESET;
    end
    else if (send)
    begin
      next_ans_valid      = 1'b1;
      next_answer.flags   = MDU_FLAGS_NONE;
      case (op_mode)
        MDU_OP_LOAD16:
          next_res = {16'h0000, operands_i.second};
        MDU_OP_LOAD32:
          next_res = {operands_i.first, operands_i.second};
        MDU_OP_UMUL:
          next_res = prod_u;
        MDU_OP_SMUL:
          next_res = prod_s;
        MDU_OP_SMAC:
        begin
          next_res = mac_sum;
          next_answer.flags[MDU_FLAG_V] = mac_ovf;
        end
        MDU_OP_UDIV, MDU_OP_SDIV:
        begin
          next_ans_valid = 1'b0;
          next_state     = MDU_DIV_WAIT;
        end
        default:
          next_res = res;
      endcase
      if (next_ans_valid)
        next_answer.data = mdu_half(next_res, out_mode);
      else
        next_answer = answer;
    end
    else if ((state == MDU_DIV_WAIT) && div_done)
    begin
      next_res          = {div_r, div_q};
      next_answer.data  = mdu_half({div_r, div_q}, out_mode);
      next_answer.flags = MDU_FLAGS_NONE;
      next_ans_valid    = 1'b1;
      next_state        = MDU_IDLE;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      mode_reg  <= MDU_MODE_RESET;
      res       <= MDU_RES_RESET;
      state     <= MDU_IDLE;
      ans_valid <= 1'b0;
      answer    <= '0;
    end
    else
    begin
      mode_reg  <= next_mode_reg;
      res       <= next_res;
      state     <= next_state;
      ans_valid <= next_ans_valid;
      answer    <= next_answer;
    end
  end

  // CPU stalls while a division runs
  assign busy_o      = (state == MDU_DIV_WAIT) || div_start;
  assign ans_valid_o = ans_valid;
  assign answer_o    = answer;
  assign mode_o      = mode_reg;

endmodule : mdu_core

/* verif/mdu_core_chk.sv */
// Port assertions for the multiply/divide coprocessor
`timescale 1ns/1ps
module mdu_core_chk
  import mdu_pkg::*;
#(
  parameter int W = MDU_DATA_W
)(
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          mode_wr_i,
  input  wire logic [15:0]   mode_data_i,
  input  wire logic          op_send_i,
  input  wire logic          init_send_i,
  input  wire mdu_operands_t operands_i,
  input  wire logic          busy_o,
  input  wire logic          ans_valid_o,
  input  wire mdu_answer_t   answer_o,
  input  wire logic [6:0]    mode_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic take;
  assign take = (op_send_i || init_send_i) && !mode_wr_i && !busy_o;
  AST_MODE_STORE: assert property (mode_wr_i && !busy_o
    |=> {9'h000, mode_o} == ($past(mode_data_i) & 16'h007F)) else $error("mode not stored");
  AST_MODE_HOLD: assert property (!mode_wr_i |=> $stable(mode_o))
    else $error("mode changed");
  AST_ANS_NEXT: assert property (take |=> ans_valid_o) else $error("late answer");
  AST_DIV_TIME: assert property ($rose(busy_o) |-> ##19 (ans_valid_o && !busy_o))
    else $error("divide time");
  AST_FLAGS_ZERO: assert property (ans_valid_o && mode_o[3:0] != MDU_OP_SMAC
    |-> answer_o.flags == MDU_FLAGS_NONE) else $error("flags set");
  AST_MAC_FLAGS: assert property (ans_valid_o |-> (answer_o.flags & 4'hB) == 4'h0)
    else $error("extra flags");
  AST_OUT_RSVD: assert property (ans_valid_o && mode_o[6:4] > MDU_OUT_HIGH
    |-> answer_o.data == 16'h0000) else $error("reserved output");
  AST_ANS_HOLD: assert property (!ans_valid_o |-> $stable(answer_o))
    else $error("answer moved");
endmodule : mdu_core_chk

bind mdu_core mdu_core_chk #(.W(W)) chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .mode_wr_i(mode_wr_i), .mode_data_i(mode_data_i), .op_send_i(op_send_i),
  .init_send_i(init_send_i), .operands_i(operands_i), .busy_o(busy_o),
  .ans_valid_o(ans_valid_o), .answer_o(answer_o), .mode_o(mode_o));

/* verif/mdu_cpu_model.sv */
// Host core model issuing coprocessor instructions
`timescale 1ns/1ps
module mdu_cpu_model
  import mdu_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         ans_valid_i,
  input  wire mdu_answer_t  answer_i,
  output logic              mode_wr_o,
  output logic [15:0]       mode_data_o,
  output logic              op_send_o,
  output logic              init_send_o,
  output mdu_operands_t     operands_o
);
  initial
  begin
    mode_wr_o = 1'b0;
    mode_data_o = 16'hA5A5;
    op_send_o = 1'b0;
    init_send_o = 1'b0;
    operands_o = 32'h5A5A_A5A5;
  end
  task automatic mode_write(input logic [6:0] mode);
    @(negedge mclk_i);
    mode_wr_o = 1'b1;
    mode_data_o = {9'h1FF, mode};
    @(negedge mclk_i);
    mode_wr_o = 1'b0;
    mode_data_o = ~mode_data_o;
  endtask : mode_write
  task automatic send(input logic init, input logic [15:0] a, input logic [15:0] b,
                      output mdu_answer_t ans, output int lat);
    @(negedge mclk_i);
    op_send_o = !init;
    init_send_o = init;
    operands_o = {a, b};
    @(negedge mclk_i);
    op_send_o = 1'b0;
    init_send_o = 1'b0;
    operands_o = ~operands_o;
    lat = 1;
    while (ans_valid_i !== 1'b1 && lat < 30)
    begin
      @(negedge mclk_i);
      lat++;
    end
    ans = answer_i;
  endtask : send
endmodule : mdu_cpu_model

/* verif/tb_coprocessor_mul_div_mac.sv */
// Self-checking bench for the multiply/divide coprocessor
`timescale 1ns/1ps
module tb_coprocessor_mul_div_mac
  import mdu_pkg::*;
;
  logic          mclk_i;
  logic          rst_n_i;
  logic          mode_wr;
  logic [15:0]   mode_data;
  logic          op_send;
  logic          init_send;
  mdu_operands_t operands;
  logic          busy;
  logic          ans_valid;
  mdu_answer_t   answer;
  logic [6:0]    mode;
  int            mismatches = 0;
  int            comparisons = 0;

  mdu_core dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_wr_i(mode_wr),
    .mode_data_i(mode_data), .op_send_i(op_send), .init_send_i(init_send),
    .operands_i(operands), .busy_o(busy), .ans_valid_o(ans_valid), .answer_o(answer),
    .mode_o(mode));
  mdu_cpu_model cpu_u (.mclk_i(mclk_i), .ans_valid_i(ans_valid), .answer_i(answer),
    .mode_wr_o(mode_wr), .mode_data_o(mode_data), .op_send_o(op_send),
    .init_send_o(init_send), .operands_o(operands));

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // Mode write (skipped for 7F), one send, answer and latency compared
  task automatic run(input logic [6:0] md, input logic [15:0] a, input logic [15:0] b,
                     input logic [19:0] exp, input int lat_exp);
    mdu_answer_t ans;
    int          lat;
    if (md != 7'h7F)
      cpu_u.mode_write(md);
    cpu_u.send(md[3:0] inside {4'h1, 4'h2}, a, b, ans, lat);
    check(ans, exp);
    check(20'(lat), 20'(lat_exp));
  endtask : run

  task automatic t_reset();
    check({13'h0000, mode}, {13'h0000, MDU_MODE_RESET});
    run(7'h7F, 16'h1111, 16'h2222, 20'h00000, 1);
  endtask : t_reset

  task automatic t_mul();
    run(7'h04, 16'hFFFF, 16'hFFFF, {16'h0001, 4'h0}, 1);
    run(7'h13, 16'h0000, 16'h0000, {16'hFFFE, 4'h0}, 1);
    run(7'h15, 16'hFFFF, 16'h0002, {16'hFFFF, 4'h0}, 1);
    run(7'h03, 16'h0000, 16'h0000, {16'hFFFE, 4'h0}, 1);
  endtask : t_mul

  task automatic t_mac();
    run(7'h02, 16'h7FFF, 16'hFFFF, {16'hFFFF, 4'h0}, 1);
    run(7'h07, 16'h0001, 16'h0001, {16'h0000, 4'h4}, 1);
    run(7'h7F, 16'h0000, 16'h0005, {16'h0000, 4'h0}, 1);
    run(7'h17, 16'hFFFF, 16'h0001, {16'h7FFF, 4'h4}, 1);
    run(7'h10, 16'h0000, 16'h0000, 20'h00000, 1);
    run(7'h01, 16'h1234, 16'h5678, {16'h5678, 4'h0}, 1);
    run(7'h13, 16'h0000, 16'h0000, 20'h00000, 1);
  endtask : t_mac

  task automatic t_div();
    run(7'h08, 16'h0064, 16'h0007, {16'h000E, 4'h0}, 19);
    run(7'h13, 16'h0000, 16'h0000, {16'h0002, 4'h0}, 1);
    check({13'h0000, mode}, 20'h00013);
    run(7'h19, 16'hFFF9, 16'h0002, {16'hFFFF, 4'h0}, 19);
    run(7'h03, 16'h0000, 16'h0000, {16'hFFFD, 4'h0}, 1);
  endtask : t_div

  task automatic t_reserved();
    for (int m = 10; m < 17; m++)
      run(7'(m == 16 ? 6 : m), 16'h0003, 16'h0003, {16'hFFFD, 4'h0}, 1);
    run(7'h23, 16'h0000, 16'h0000, 20'h00000, 1);
    run(7'h13, 16'h0000, 16'h0000, {16'hFFFF, 4'h0}, 1);
  endtask : t_reserved

  initial
  begin
    rst_n_i = 1'b0;
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_mul();
    t_mac();
    t_div();
    t_reserved();
    report_and_stop();
  end

  initial
  begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    report_and_stop();
  end
endmodule : tb_coprocessor_mul_div_mac
